// file: core/cfdt_cfg.svh
`ifndef CFDT_CFG_SVH
`define CFDT_CFG_SVH

// ****************************************
// Register offsets
// ****************************************
`define CFDT_OFS_DBT 8'h00
`define CFDT_OFS_TDC 8'h04
`define CFDT_OFS_TBC 8'h08
`define CFDT_OFS_TSCON 8'h0C
`define CFDT_OFS_MODE 8'h10
`define CFDT_OFS_STAT 8'h14

// ****************************************
// Field positions
// ****************************************
`define CFDT_DBT_PRE_LSB 24
`define CFDT_DBT_SEG1_LSB 16
`define CFDT_DBT_SEG2_LSB 8
`define CFDT_DBT_SJW_LSB 0
`define CFDT_TDC_FILT_BIT 25
`define CFDT_TDC_ID12_BIT 24
`define CFDT_TDC_MODE_LSB 16
`define CFDT_TDC_OFS_LSB 8
`define CFDT_TDC_VAL_LSB 0
`define CFDT_TS_RES_BIT 18
`define CFDT_TS_EOF_BIT 17
`define CFDT_TS_EN_BIT 16
`define CFDT_TS_PRE_LSB 0
`define CFDT_MODE_OP_LSB 0
`define CFDT_MODE_RSD_BIT 4
`define CFDT_STAT_MEAS_LSB 0
`define CFDT_STAT_SSP_LSB 8
`define CFDT_STAT_PHASE_LSB 24
`define CFDT_STAT_DATA_BIT 28

// ****************************************
// Reset values and codes
// ****************************************
`define CFDT_PRE_RST 8'h00
`define CFDT_SEG1_RST 5'h0E
`define CFDT_SEG2_RST 4'h3
`define CFDT_SJW_RST 4'h3
`define CFDT_TDC_MODE_RST 2'h2
`define CFDT_TDC_OFS_RST 7'h10
`define CFDT_TDC_VAL_RST 6'h00
`define CFDT_TBC_RST 32'h00000000
`define CFDT_TB_PRE_RST 10'h000
`define CFDT_OPMODE_RST 3'h4
`define CFDT_OPMODE_CFG 3'h4

// ****************************************
// Timing counts
// ****************************************
`define CFDT_DELAY_MAX 6'h3F

`endif

// file: core/cfdt_pkg.sv
package cfdt_pkg;

    typedef enum logic [1:0] {
        CFDT_PH_SYNC = 2'b00,
        CFDT_PH_SEG1 = 2'b01,
        CFDT_PH_SEG2 = 2'b10
    } cfdt_phase_t;

    typedef enum logic [1:0] {
        CFDT_COMP_OFF = 2'b00,
        CFDT_COMP_MANUAL = 2'b01,
        CFDT_COMP_AUTO = 2'b10,
        CFDT_COMP_AUTO_ALT = 2'b11
    } cfdt_comp_mode_t;

endpackage

// file: core/cfdt_sync3.sv
`timescale 1ns/100ps

module cfdt_sync3 import cfdt_pkg::*; (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic din,
    output logic level_q
);

    logic s1_q;
    logic s2_q;
    logic s3_q;

    // ****************************************
    // Three stages, change taken when last two agree
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            s1_q <= 1'b1;
            s2_q <= 1'b1;
            s3_q <= 1'b1;
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            level_q <= 1'b1;
        end else if (s2_q == s3_q) begin
            level_q <= s3_q;
        end
    end

endmodule

// file: core/cfdt_tick_div.sv
`timescale 1ns/100ps

module cfdt_tick_div import cfdt_pkg::*; #(
    parameter int WIDTH = 8
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic en,
    input wire logic clear,
    input wire logic [WIDTH-1:0] limit,
    output logic tick_q
);

    logic [WIDTH-1:0] count_q;

    // ****************************************
    // One tick every limit+1 cycles
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (reset || clear || !en) begin
            count_q <= '0;
            tick_q <= 1'b0;
        end else if (count_q >= limit) begin
            count_q <= '0;
            tick_q <= 1'b1;
        end else begin
            count_q <= count_q + 1'b1;
            tick_q <= 1'b0;
        end
    end

    property p_tick_gap;
        @(posedge sys_clk) disable iff (reset)
        tick_q && en && !clear && (limit != '0) && $stable(limit) |=> !tick_q;
    endproperty
    a_tick_gap: assert property (p_tick_gap) else $error("tick repeated too soon");

endmodule

// file: core/cfdt_data_timing.sv
// The implementer's own choices: the address map and the address-and-strobe port.
`timescale 1ns/100ps
`include "cfdt_cfg.svh"

module cfdt_data_timing import cfdt_pkg::*; (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic can_rx_pin,
    input wire logic brs_window,
    input wire logic bus_integrating,
    input wire logic frame_is_fd,
    input wire logic loop_tx_edge,
    input wire logic ts_sof_evt,
    input wire logic ts_fdf_evt,
    input wire logic ts_eof_evt,
    output logic [31:0] reg_rdata_q,
    output logic data_timing_q,
    output logic tq_tick_q,
    output logic sample_pt_q,
    output logic bit_start_q,
    output logic ssp_pt_q,
    output logic edge_filter_q,
    output logic id12_en_q,
    output logic [31:0] stamp_q,
    output logic stamp_valid_q
);

    // ****************************************
    // Register state
    // ****************************************
    logic [7:0] pre_q;
    logic [4:0] seg1_q;
    logic [3:0] seg2_q;
    logic [3:0] sjw_q;
    logic filt_en_q;
    logic id12_q;
    cfdt_comp_mode_t cmode_q;
    logic [6:0] cofs_q;
    logic [5:0] cval_q;
    logic [31:0] tbc_q;
    logic ts_res_q;
    logic ts_eof_q;
    logic tb_en_q;
    logic [9:0] tb_pre_q;
    logic [2:0] opmode_q;
    logic rsd_q;

    logic cfg_open;
    logic wr_dbt;
    logic wr_tdc;
    logic tbc_wr;
    logic tb_tick;

    assign cfg_open = (opmode_q == `CFDT_OPMODE_CFG);
    assign wr_dbt = reg_wr && (reg_addr == `CFDT_OFS_DBT) && cfg_open;
    assign wr_tdc = reg_wr && (reg_addr == `CFDT_OFS_TDC) && cfg_open;
    assign tbc_wr = reg_wr && (reg_addr == `CFDT_OFS_TBC);

    // ****************************************
    // Timing and compensation settings
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pre_q <= `CFDT_PRE_RST;
            seg1_q <= `CFDT_SEG1_RST;
            seg2_q <= `CFDT_SEG2_RST;
            sjw_q <= `CFDT_SJW_RST;
        end else if (wr_dbt) begin
            pre_q <= reg_wdata[`CFDT_DBT_PRE_LSB +: 8];
            seg1_q <= reg_wdata[`CFDT_DBT_SEG1_LSB +: 5];
            seg2_q <= reg_wdata[`CFDT_DBT_SEG2_LSB +: 4];
            sjw_q <= reg_wdata[`CFDT_DBT_SJW_LSB +: 4];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            filt_en_q <= 1'b0;
            id12_q <= 1'b0;
            cmode_q <= cfdt_comp_mode_t'(`CFDT_TDC_MODE_RST);
            cofs_q <= `CFDT_TDC_OFS_RST;
            cval_q <= `CFDT_TDC_VAL_RST;
        end else if (wr_tdc) begin
            filt_en_q <= reg_wdata[`CFDT_TDC_FILT_BIT];
            id12_q <= reg_wdata[`CFDT_TDC_ID12_BIT];
            cmode_q <= cfdt_comp_mode_t'(reg_wdata[`CFDT_TDC_MODE_LSB +: 2]);
            cofs_q <= reg_wdata[`CFDT_TDC_OFS_LSB +: 7];
            cval_q <= reg_wdata[`CFDT_TDC_VAL_LSB +: 6];
        end
    end

    // ****************************************
    // Mode and time stamp control
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            opmode_q <= `CFDT_OPMODE_RST;
            rsd_q <= 1'b0;
        end else if (reg_wr && (reg_addr == `CFDT_OFS_MODE)) begin
            opmode_q <= reg_wdata[`CFDT_MODE_OP_LSB +: 3];
            rsd_q <= reg_wdata[`CFDT_MODE_RSD_BIT];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ts_res_q <= 1'b0;
            ts_eof_q <= 1'b0;
            tb_en_q <= 1'b0;
            tb_pre_q <= `CFDT_TB_PRE_RST;
        end else if (reg_wr && (reg_addr == `CFDT_OFS_TSCON)) begin
            ts_res_q <= reg_wdata[`CFDT_TS_RES_BIT];
            ts_eof_q <= reg_wdata[`CFDT_TS_EOF_BIT];
            tb_en_q <= reg_wdata[`CFDT_TS_EN_BIT];
            tb_pre_q <= reg_wdata[`CFDT_TS_PRE_LSB +: 10];
        end
    end

    // ****************************************
    // Phase selection and receive edges
    // ****************************************
    logic rx_s;
    logic rx_prev_q;
    logic rx_prev2_q;
    logic edge_ok;

    cfdt_sync3 u_rx_sync (
        .sys_clk(sys_clk),
        .reset(reset),
        .din(can_rx_pin),
        .level_q(rx_s)
    );

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            rx_prev_q <= 1'b1;
            rx_prev2_q <= 1'b1;
        end else begin
            rx_prev_q <= rx_s;
            rx_prev2_q <= rx_prev_q;
        end
    end

    // Filtered edge needs two dominant samples in a row
    assign edge_ok = edge_filter_q ? (rx_prev2_q && !rx_prev_q && !rx_s)
                                   : (rx_prev_q && !rx_s);

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            data_timing_q <= 1'b0;
            edge_filter_q <= 1'b0;
            id12_en_q <= 1'b0;
        end else begin
            data_timing_q <= brs_window && !rsd_q;
            edge_filter_q <= filt_en_q && bus_integrating;
            id12_en_q <= id12_q;
        end
    end

    // ****************************************
    // Data bit timing
    // ****************************************
    cfdt_phase_t phase_q;
    logic [5:0] cnt_q;
    logic [5:0] ext_q;
    logic [5:0] cut_q;
    logic resynced_q;
    logic edge_pend_q;
    logic [5:0] cnt_nx;
    logic [5:0] sjw_len;
    logic [5:0] seg1_len;
    logic [5:0] seg2_len;
    logic [5:0] seg2_left;

    cfdt_tick_div #(.WIDTH(8)) u_tq_div (
        .sys_clk(sys_clk),
        .reset(reset),
        .en(data_timing_q),
        .clear(1'b0),
        .limit(pre_q),
        .tick_q(tq_tick_q)
    );

    assign cnt_nx = cnt_q + 6'd1;
    assign sjw_len = {2'b00, sjw_q} + 6'd1;
    assign seg1_len = {1'b0, seg1_q} + 6'd1 + ext_q;
    assign seg2_len = {2'b00, seg2_q} + 6'd1 - cut_q;
    assign seg2_left = seg2_len - cnt_q;

    always_ff @(posedge sys_clk) begin
        if (reset || !data_timing_q) begin
            edge_pend_q <= 1'b0;
        end else if (edge_ok) begin
            edge_pend_q <= 1'b1;
        end else if (tq_tick_q) begin
            edge_pend_q <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset || !data_timing_q) begin
            phase_q <= CFDT_PH_SYNC;
            cnt_q <= 6'd0;
            ext_q <= 6'd0;
            cut_q <= 6'd0;
            resynced_q <= 1'b0;
            sample_pt_q <= 1'b0;
            bit_start_q <= 1'b0;
        end else begin
            sample_pt_q <= 1'b0;
            bit_start_q <= 1'b0;
            if (tq_tick_q) begin
                case (phase_q)
                    CFDT_PH_SYNC: begin
                        phase_q <= CFDT_PH_SEG1;
                        cnt_q <= 6'd0;
                        ext_q <= 6'd0;
                        cut_q <= 6'd0;
                        resynced_q <= 1'b0;
                    end
                    CFDT_PH_SEG1: begin
                        if (edge_pend_q && !resynced_q) begin
                            ext_q <= (cnt_nx < sjw_len) ? cnt_nx : sjw_len;
                            resynced_q <= 1'b1;
                            cnt_q <= cnt_nx;
                        end else if (cnt_nx >= seg1_len) begin
                            phase_q <= CFDT_PH_SEG2;
                            cnt_q <= 6'd0;
                            sample_pt_q <= 1'b1;
                        end else begin
                            cnt_q <= cnt_nx;
                        end
                    end
                    CFDT_PH_SEG2: begin
                        if (edge_pend_q && !resynced_q && (seg2_left <= sjw_len)) begin
                            phase_q <= CFDT_PH_SEG1;
                            cnt_q <= 6'd0;
                            ext_q <= 6'd0;
                            cut_q <= 6'd0;
                            resynced_q <= 1'b1;
                            bit_start_q <= 1'b1;
                        end else if (edge_pend_q && !resynced_q) begin
                            cut_q <= sjw_len;
                            resynced_q <= 1'b1;
                            cnt_q <= cnt_nx;
                        end else if (cnt_nx >= seg2_len) begin
                            phase_q <= CFDT_PH_SYNC;
                            cnt_q <= 6'd0;
                            bit_start_q <= 1'b1;
                        end else begin
                            cnt_q <= cnt_nx;
                        end
                    end
                    default: begin
                        phase_q <= CFDT_PH_SYNC;
                        cnt_q <= 6'd0;
                    end
                endcase
            end
        end
    end

    // ****************************************
    // Transmitter delay compensation
    // ****************************************
    logic meas_run_q;
    logic [5:0] meas_cnt_q;
    logic [5:0] meas_q;
    logic [14:0] seg1_cyc;
    logic [14:0] ssp_base;
    logic [15:0] ssp_sum;
    logic [14:0] ssp_pos_q;
    logic [14:0] ssp_cnt_q;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            meas_run_q <= 1'b0;
            meas_cnt_q <= 6'd0;
            meas_q <= 6'd0;
        end else if (loop_tx_edge) begin
            meas_run_q <= 1'b1;
            meas_cnt_q <= 6'd0;
        end else if (meas_run_q && (edge_ok || meas_cnt_q == `CFDT_DELAY_MAX)) begin
            meas_run_q <= 1'b0;
            meas_q <= meas_cnt_q;
        end else if (meas_run_q) begin
            meas_cnt_q <= meas_cnt_q + 6'd1;
        end
    end

    assign seg1_cyc = ({10'h000, seg1_q} + 15'd1) * ({7'h00, pre_q} + 15'd1);
    assign ssp_base = (cmode_q == CFDT_COMP_MANUAL) ? {9'h000, cval_q}
                                                    : {9'h000, meas_q} + seg1_cyc;
    assign ssp_sum = {1'b0, ssp_base} + {{9{cofs_q[6]}}, cofs_q};

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ssp_pos_q <= 15'd0;
        end else begin
            ssp_pos_q <= ssp_sum[15] ? 15'd0 : ssp_sum[14:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset || !data_timing_q || bit_start_q) begin
            ssp_cnt_q <= 15'd0;
        end else if (ssp_cnt_q != 15'h7FFF) begin
            ssp_cnt_q <= ssp_cnt_q + 15'd1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ssp_pt_q <= 1'b0;
        end else begin
            ssp_pt_q <= data_timing_q && (cmode_q != CFDT_COMP_OFF)
                        && (ssp_cnt_q == ssp_pos_q);
        end
    end

    // ****************************************
    // Time base counter and time stamps
    // ****************************************
    logic stamp_evt;

    cfdt_tick_div #(.WIDTH(10)) u_tb_div (
        .sys_clk(sys_clk),
        .reset(reset),
        .en(tb_en_q),
        .clear(tbc_wr),
        .limit(tb_pre_q),
        .tick_q(tb_tick)
    );

    always_ff @(posedge sys_clk) begin
        if (reset || !tb_en_q) begin
            tbc_q <= `CFDT_TBC_RST;
        end else if (tbc_wr) begin
            tbc_q <= reg_wdata;
        end else if (tb_tick) begin
            tbc_q <= tbc_q + 32'd1;
        end
    end

    assign stamp_evt = ts_eof_q ? ts_eof_evt
                     : (frame_is_fd && ts_res_q) ? ts_fdf_evt : ts_sof_evt;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            stamp_q <= 32'h00000000;
            stamp_valid_q <= 1'b0;
        end else begin
            stamp_valid_q <= stamp_evt;
            if (stamp_evt) begin
                stamp_q <= tbc_q;
            end
        end
    end

    // ****************************************
    // Register read port
    // ****************************************
    logic [31:0] rd_mux;

    always_comb begin
        rd_mux = 32'h00000000;
        case (reg_addr)
            `CFDT_OFS_DBT: begin
                rd_mux[`CFDT_DBT_PRE_LSB +: 8] = pre_q;
                rd_mux[`CFDT_DBT_SEG1_LSB +: 5] = seg1_q;
                rd_mux[`CFDT_DBT_SEG2_LSB +: 4] = seg2_q;
                rd_mux[`CFDT_DBT_SJW_LSB +: 4] = sjw_q;
            end
            `CFDT_OFS_TDC: begin
                rd_mux[`CFDT_TDC_FILT_BIT] = filt_en_q;
                rd_mux[`CFDT_TDC_ID12_BIT] = id12_q;
                rd_mux[`CFDT_TDC_MODE_LSB +: 2] = cmode_q;
                rd_mux[`CFDT_TDC_OFS_LSB +: 7] = cofs_q;
                rd_mux[`CFDT_TDC_VAL_LSB +: 6] = cval_q;
            end
            `CFDT_OFS_TBC: rd_mux = tbc_q;
            `CFDT_OFS_TSCON: begin
                rd_mux[`CFDT_TS_RES_BIT] = ts_res_q;
                rd_mux[`CFDT_TS_EOF_BIT] = ts_eof_q;
                rd_mux[`CFDT_TS_EN_BIT] = tb_en_q;
                rd_mux[`CFDT_TS_PRE_LSB +: 10] = tb_pre_q;
            end
            `CFDT_OFS_MODE: begin
                rd_mux[`CFDT_MODE_OP_LSB +: 3] = opmode_q;
                rd_mux[`CFDT_MODE_RSD_BIT] = rsd_q;
            end
            `CFDT_OFS_STAT: begin
                rd_mux[`CFDT_STAT_MEAS_LSB +: 6] = meas_q;
                rd_mux[`CFDT_STAT_SSP_LSB +: 15] = ssp_pos_q;
                rd_mux[`CFDT_STAT_PHASE_LSB +: 2] = phase_q;
                rd_mux[`CFDT_STAT_DATA_BIT] = data_timing_q;
            end
            default: rd_mux = 32'h00000000;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (reset || !reg_rd) begin
            reg_rdata_q <= 32'h00000000;
        end else begin
            reg_rdata_q <= rd_mux;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    property p_cfg_lock;
        reg_wr && (reg_addr == `CFDT_OFS_DBT) && !cfg_open |=> $stable({pre_q, seg1_q, seg2_q, sjw_q});
    endproperty
    a_cfg_lock: assert property (p_cfg_lock) else $error("timing changed outside config");

    property p_manual_val;
        wr_tdc |=> cval_q == $past(reg_wdata[5:0]);
    endproperty
    a_manual_val: assert property (p_manual_val) else $error("compensation value not stored");

    property p_unimpl;
        reg_rd && (reg_addr == `CFDT_OFS_DBT) |=>
            (reg_rdata_q[23:21] == 3'h0) && (reg_rdata_q[15:12] == 4'h0) && (reg_rdata_q[7:4] == 4'h0);
    endproperty
    a_unimpl: assert property (p_unimpl) else $error("unimplemented bits not zero");

    property p_tb_clear;
        !tb_en_q ##1 !tb_en_q |-> tbc_q == 32'h00000000;
    endproperty
    a_tb_clear: assert property (p_tb_clear) else $error("counter not zero while disabled");

    property p_tb_step;
        tb_en_q && tb_tick && !tbc_wr && (tbc_q != 32'hFFFFFFFF) ##1 tb_en_q
            |-> tbc_q == $past(tbc_q) + 32'd1;
    endproperty
    a_tb_step: assert property (p_tb_step) else $error("counter did not advance");

    property p_tb_wrap;
        tb_en_q && tb_tick && !tbc_wr && (tbc_q == 32'hFFFFFFFF) ##1 tb_en_q |-> tbc_q == 32'h0;
    endproperty
    a_tb_wrap: assert property (p_tb_wrap) else $error("counter did not wrap");

    property p_tb_load;
        tb_en_q && tbc_wr ##1 tb_en_q |-> tbc_q == $past(reg_wdata);
    endproperty
    a_tb_load: assert property (p_tb_load) else $error("counter write lost");

    property p_rsd;
        rsd_q |=> !data_timing_q;
    endproperty
    a_rsd: assert property (p_rsd) else $error("data timing despite switch disable");

    property p_comp_off;
        (cmode_q == CFDT_COMP_OFF) && ($past(cmode_q) == CFDT_COMP_OFF) |-> !ssp_pt_q;
    endproperty
    a_comp_off: assert property (p_comp_off) else $error("secondary sample while disabled");

    property p_sample;
        sample_pt_q |-> (phase_q == CFDT_PH_SEG2) && (cnt_q == 6'd0);
    endproperty
    a_sample: assert property (p_sample) else $error("sample point outside segment two");

    property p_stamp;
        stamp_evt |=> stamp_valid_q && (stamp_q == $past(tbc_q));
    endproperty
    a_stamp: assert property (p_stamp) else $error("time stamp not captured");

endmodule

// file: tb/cfdt_can_node.sv
`timescale 1ns/100ps
// ****
// Far node, recessive when idle
// ****
module cfdt_can_node (
    input wire logic sys_clk,
    input wire logic dom,
    output logic can_rx_pin
);
    initial can_rx_pin = 1'b1;
    always @(posedge sys_clk) begin
        can_rx_pin <= ~dom;
    end
endmodule

// file: tb/tb_top.sv
`timescale 1ns/100ps
module tb_top import cfdt_pkg::*; ;
    logic sys_clk = 0, reset = 1, wr = 0, rd = 0, brs = 0, integ = 0;
    logic sof = 0, eof = 0, dom = 0, rx, dt, tq, sp, bs, ssp, ef, id12, sv;
    logic fd = 0, fdf = 0, lte = 0;
    logic [7:0] addr = 0;
    logic [31:0] wd = 0, rdat, st, v, v2;
    int errors = 0, n_tests = 0, n;
    always #10 sys_clk = ~sys_clk;
    cfdt_can_node node_u (.sys_clk(sys_clk), .dom(dom), .can_rx_pin(rx));
    cfdt_data_timing dut_u (.sys_clk(sys_clk), .reset(reset), .reg_addr(addr),
        .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd), .can_rx_pin(rx), .brs_window(brs),
        .bus_integrating(integ), .frame_is_fd(fd), .loop_tx_edge(lte),
        .ts_sof_evt(sof), .ts_fdf_evt(fdf), .ts_eof_evt(eof), .reg_rdata_q(rdat),
        .data_timing_q(dt), .tq_tick_q(tq), .sample_pt_q(sp), .bit_start_q(bs),
        .ssp_pt_q(ssp), .edge_filter_q(ef), .id12_en_q(id12), .stamp_q(st),
        .stamp_valid_q(sv));
    // ****
    // Bus tasks and compare
    // ****
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        addr <= a; wd <= d; wr <= 1'b1;
        @(posedge sys_clk); wr <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        addr <= a; rd <= 1'b1;
        @(posedge sys_clk); rd <= 1'b0;
        #1 d = rdat;
        @(posedge sys_clk);
    endtask
    task automatic meas(input int s, output int c);
        int k;
        k = 0;
        do begin @(posedge sys_clk); #1 k++; end
            while (((s == 0) ? tq : bs) !== 1'b1 && k < 99);
        c = 0;
        do begin @(posedge sys_clk); #1 c++; end
            while (((s == 0) ? tq : (s == 1) ? bs : (s == 2) ? ssp : sp) !== 1'b1 && c < 99);
    endtask
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        #200us errors++;
        finish_test;
    end
    // ****
    // Tests
    // ****
    initial begin
        repeat (6) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        rd_reg(8'h00, v); chk(v, 32'h000E0303);
        rd_reg(8'h04, v); chk(v, 32'h00021000);
        rd_reg(8'h08, v); chk(v, 32'h0);
        wr_reg(8'h00, 32'hFFFFFFFF);
        rd_reg(8'h00, v); chk(v, 32'hFF1F0F0F);
        wr_reg(8'h04, 32'hFFFFFFFF);
        rd_reg(8'h04, v); chk(v, 32'h03037F3F);
        chk(id12, 1'b1);
        integ <= 1'b1;
        @(posedge sys_clk); #1 chk(ef, 1'b1);
        @(posedge sys_clk);
        wr_reg(8'h10, 32'h0);
        wr_reg(8'h00, 32'h0);
        wr_reg(8'h04, 32'h0);
        rd_reg(8'h00, v); chk(v, 32'hFF1F0F0F);
        rd_reg(8'h04, v); chk(v, 32'h03037F3F);
        rd_reg(8'h40, v); chk(v, 32'h0);
        wr_reg(8'h10, 32'h4);
        $display("register test done");
        wr_reg(8'h00, 32'h01010100);
        wr_reg(8'h04, 32'h00017E05);
        rd_reg(8'h14, v); chk(v, 32'h00000300);
        chk(ef, 1'b0);
        chk(id12, 1'b0);
        brs <= 1'b1;
        meas(1, n); chk(n, 10);
        meas(0, n); chk(n, 2);
        meas(3, n); chk(n, 6);
        meas(2, n); chk(n, 5);
        chk(dt, 1'b1);
        wr_reg(8'h10, 32'h14);
        @(posedge sys_clk); #1 chk(dt, 1'b0);
        @(posedge sys_clk);
        wr_reg(8'h10, 32'h4);
        brs <= 1'b0;
        repeat (2) @(posedge sys_clk);
        #1 chk(dt, 1'b0);
        wr_reg(8'h04, 32'h00020000);
        lte <= 1'b1;
        dom <= 1'b1;
        @(posedge sys_clk); lte <= 1'b0;
        repeat (8) @(posedge sys_clk);
        dom <= 1'b0;
        rd_reg(8'h14, v); chk(v, 32'h00000804);
        wr_reg(8'h04, 32'h0);
        rd_reg(8'h04, v); chk(v, 32'h0);
        $display("timing test done");
        wr_reg(8'h0C, 32'h00010002);
        wr_reg(8'h08, 32'hFFFFFFFC);
        rd_reg(8'h08, v);
        repeat (28) @(posedge sys_clk);
        rd_reg(8'h08, v2);
        chk(v2 - v, 32'd10);
        chk(v2 < 32'd10, 1'b1);
        addr <= 8'h08; rd <= 1'b1; sof <= 1'b1;
        @(posedge sys_clk); rd <= 1'b0; sof <= 1'b0;
        #1 chk(sv, 1'b1);
        chk(st, 32'h00000006);
        chk(rdat, 32'h00000006);
        @(posedge sys_clk);
        wr_reg(8'h0C, 32'h00030002);
        sof <= 1'b1;
        @(posedge sys_clk); sof <= 1'b0;
        #1 chk(sv, 1'b0);
        @(posedge sys_clk); eof <= 1'b1;
        @(posedge sys_clk); eof <= 1'b0;
        #1 chk(sv, 1'b1);
        @(posedge sys_clk);
        wr_reg(8'h0C, 32'h00050002);
        fd <= 1'b1;
        sof <= 1'b1;
        @(posedge sys_clk); sof <= 1'b0; fdf <= 1'b1;
        #1 chk(sv, 1'b0);
        @(posedge sys_clk); fdf <= 1'b0; fd <= 1'b0;
        #1 chk(sv, 1'b1);
        @(posedge sys_clk);
        wr_reg(8'h0C, 32'h0);
        rd_reg(8'h08, v); chk(v, 32'h0);
        $display("counter test done");
        finish_test;
    end
endmodule
